/* src/io_line_defines.vh */
// register map, reset values and line layout of the io line controller
`ifndef IO_LINE_DEFINES_VH
`define IO_LINE_DEFINES_VH

// ****************************************
// line layout
// ****************************************
`define LINE_W          32
`define LINE_MASK       32'h3fffffff

// ****************************************
// register byte offsets
// ****************************************
`define OFF_OWN_SET     8'h00
`define OFF_OWN_CLR     8'h04
`define OFF_OWN_STATE   8'h08
`define OFF_DRV_SET     8'h10
`define OFF_DRV_CLR     8'h14
`define OFF_DRV_STATE   8'h18
`define OFF_DGL_SET     8'h20
`define OFF_DGL_CLR     8'h24
`define OFF_DGL_STATE   8'h28
`define OFF_LVL_SET     8'h30
`define OFF_LVL_CLR     8'h34
`define OFF_LVL_STATE   8'h38
`define OFF_PIN_STATE   8'h3c

// ****************************************
// reset values
// ****************************************
`define RST_OWN         32'h3fffffff
`define RST_DRV         32'h00000000
`define RST_DGL         32'h00000000
`define RST_LVL         32'h00000000

// ****************************************
// bus encodings
// ****************************************
`define HTRANS_NONSEQ   2'h2
`define HRESP_OKAY      1'h0

`endif

/* src/line_sync.v */
// two-flop synchroniser for the pad input levels
`timescale 1ns/1ns
`include "io_line_defines.vh"

module line_sync (
    // clock and reset
    input  wire                  hclk,
    input  wire                  hresetn,
    // pad levels
    input  wire [`LINE_W-1:0]    async_in,
    output wire [`LINE_W-1:0]    sync_out
);

    reg [`LINE_W-1:0] stage1_ff;
    reg [`LINE_W-1:0] stage2_ff;

    // first stage feeds only the second stage
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1_ff <= 32'h00000000;
            stage2_ff <= 32'h00000000;
        end else begin
            stage1_ff <= async_in;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_out = stage2_ff;

endmodule // line_sync

/* src/deglitch_filter.v */
// per-line input glitch filter, bypassed where a line's filter is off
`timescale 1ns/1ns
`include "io_line_defines.vh"

module deglitch_filter (
    // clock and reset
    input  wire                  hclk,
    input  wire                  hresetn,
    // synchronised levels and per-line enables
    input  wire [`LINE_W-1:0]    level_in,
    input  wire [`LINE_W-1:0]    filt_en,
    // filtered levels
    output wire [`LINE_W-1:0]    level_out
);

    reg [`LINE_W-1:0] prev_ff;
    reg [`LINE_W-1:0] out_ff;

    genvar i;
    generate
        for (i = 0; i < `LINE_W; i = i + 1) begin : g_line
            // a filtered line moves only after two equal samples
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    prev_ff[i] <= 1'b0;
                    out_ff[i]  <= 1'b0;
                end else begin
                    prev_ff[i] <= level_in[i];
                    if (!filt_en[i] || (level_in[i] == prev_ff[i])) begin
                        out_ff[i] <= level_in[i];
                    end
                end
            end
        end
    endgenerate

    assign level_out = out_ff;

endmodule // deglitch_filter

/* src/io_line_bank.v */
// io line control bank: ahb-lite register slave, per-line state and pad mux
// What this block does
// RULE_01: A one written to a bit of ctrl_own_set gives that line to the controller.
// RULE_02: A one written to a bit of ctrl_own_clear hands that line to its peripheral.
// RULE_03: ctrl_own_state reads one where the controller owns the line, zero otherwise.
// RULE_04: A one written to a bit of drive_on_set enables that line's output driver.
// RULE_05: A one written to a bit of drive_on_clear makes that line input only.
// RULE_06: drive_on_state reads one where the output is enabled, zero for pure input.
// RULE_07: A one written to a bit of deglitch_set switches that line's filter on.
// RULE_08: A one written to a bit of deglitch_clear switches that line's filter off.
// RULE_09: deglitch_state reads one where the filter is on, zero where it is off.
// RULE_10: A one written to a bit of out_level_set makes that line drive high.
// RULE_11: A one written to a bit of out_level_clear makes that line drive low.
// RULE_12: Bits of unimplemented lines ignore writes and read zero everywhere.
// RULE_13: Each set/clear pair acts on one state bit per line; write-only reads zero.
// RULE_14: A set or clear lands on the edge closing the write, seen by the next read.
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ns
`include "io_line_defines.vh"

module io_line_bank (
    // clock and reset
    input  wire                  hclk,
    input  wire                  hresetn,
    // ahb-lite slave
    input  wire                  hsel,
    input  wire [31:0]           haddr,
    input  wire [1:0]            htrans,
    input  wire                  hwrite,
    input  wire [2:0]            hsize,
    input  wire [31:0]           hwdata,
    input  wire                  hready,
    output wire                  hreadyout,
    output wire                  hresp,
    output wire [31:0]           hrdata,
    // pads
    input  wire [`LINE_W-1:0]    pad_in,
    output wire [`LINE_W-1:0]    pad_out,
    output wire [`LINE_W-1:0]    pad_oe_n,
    // multiplexed peripheral
    input  wire [`LINE_W-1:0]    periph_out,
    input  wire [`LINE_W-1:0]    periph_oe,
    output wire [`LINE_W-1:0]    periph_in
);

    // ****************************************
    // declarations
    // ****************************************
    reg                  wr_pend_ff;
    reg  [7:0]           wr_addr_ff;
    reg                  rd_pend_ff;
    reg  [7:0]           rd_addr_ff;
    reg  [31:0]          hrdata_ff;
    reg  [`LINE_W-1:0]   own_ff;
    reg  [`LINE_W-1:0]   drv_ff;
    reg  [`LINE_W-1:0]   dgl_ff;
    reg  [`LINE_W-1:0]   lvl_ff;
    reg  [`LINE_W-1:0]   nxt_own_ff;
    reg  [`LINE_W-1:0]   nxt_drv_ff;
    reg  [`LINE_W-1:0]   nxt_dgl_ff;
    reg  [`LINE_W-1:0]   nxt_lvl_ff;
    reg  [31:0]          nxt_hrdata_ff;
    wire                 addr_take;
    wire [`LINE_W-1:0]   wr_bits;
    wire [`LINE_W-1:0]   pin_sync;
    wire [`LINE_W-1:0]   pin_filt;
    wire                 hit_own_set;
    wire                 hit_own_clr;
    wire                 hit_drv_set;
    wire                 hit_drv_clr;
    wire                 hit_dgl_set;
    wire                 hit_dgl_clr;
    wire                 hit_lvl_set;
    wire                 hit_lvl_clr;
    wire                 wr_take;
    wire                 rd_take;
    wire [`LINE_W-1:0]   own_state;
    wire [`LINE_W-1:0]   drv_state;
    wire [`LINE_W-1:0]   dgl_state;
    wire [`LINE_W-1:0]   lvl_state;
    wire [`LINE_W-1:0]   pin_state;
    genvar               i;

    // ****************************************
    // bus address phase
    // ****************************************

    // a transfer is taken when selected, nonseq and the bus is ready
    assign addr_take = hsel && (htrans == `HTRANS_NONSEQ) && hready;

    // a taken transfer becomes a pending write or a pending read
    assign wr_take = addr_take && hwrite;
    assign rd_take = addr_take && !hwrite;

    // writes finish with no wait, reads insert one wait cycle
    assign hreadyout = ~rd_pend_ff;

    // no error case exists, so the response stays okay
    assign hresp     = `HRESP_OKAY;

    // read data comes straight from its flop
    assign hrdata    = hrdata_ff;

    // pending flags last exactly one clock cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
        end else begin
            wr_pend_ff <= wr_take;
            rd_pend_ff <= rd_take;
        end
    end

    // word address of the transfer, held until the next one is taken
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_addr_ff <= 8'h00;
            rd_addr_ff <= 8'h00;
        end else if (addr_take) begin
            wr_addr_ff <= {haddr[7:2], 2'h0};
            rd_addr_ff <= {haddr[7:2], 2'h0};
        end
    end

    // ****************************************
    // write decode
    // ****************************************

    // write data limited to the lines that exist
    assign wr_bits = hwdata & `LINE_MASK; // RULE_12

    assign hit_own_set = wr_pend_ff && (wr_addr_ff == `OFF_OWN_SET);
    assign hit_own_clr = wr_pend_ff && (wr_addr_ff == `OFF_OWN_CLR);
    assign hit_drv_set = wr_pend_ff && (wr_addr_ff == `OFF_DRV_SET);
    assign hit_drv_clr = wr_pend_ff && (wr_addr_ff == `OFF_DRV_CLR);
    assign hit_dgl_set = wr_pend_ff && (wr_addr_ff == `OFF_DGL_SET);
    assign hit_dgl_clr = wr_pend_ff && (wr_addr_ff == `OFF_DGL_CLR);
    assign hit_lvl_set = wr_pend_ff && (wr_addr_ff == `OFF_LVL_SET);
    assign hit_lvl_clr = wr_pend_ff && (wr_addr_ff == `OFF_LVL_CLR);

    // ****************************************
    // per-line state next values
    // ****************************************

    // ownership pair sets or clears only the bits written as one
    always @* begin
        nxt_own_ff = own_ff;
        if (hit_own_set) begin
            nxt_own_ff = own_ff | wr_bits; // RULE_01
        end
        if (hit_own_clr) begin
            nxt_own_ff = own_ff & ~wr_bits; // RULE_02
        end
    end

    // driver pair sets or clears only the bits written as one
    always @* begin
        nxt_drv_ff = drv_ff;
        if (hit_drv_set) begin
            nxt_drv_ff = drv_ff | wr_bits; // RULE_04
        end
        if (hit_drv_clr) begin
            nxt_drv_ff = drv_ff & ~wr_bits; // RULE_05
        end
    end

    // filter pair sets or clears only the bits written as one
    always @* begin
        nxt_dgl_ff = dgl_ff;
        if (hit_dgl_set) begin
            nxt_dgl_ff = dgl_ff | wr_bits; // RULE_07
        end
        if (hit_dgl_clr) begin
            nxt_dgl_ff = dgl_ff & ~wr_bits; // RULE_08
        end
    end

    // level pair sets or clears only the bits written as one
    always @* begin
        nxt_lvl_ff = lvl_ff;
        if (hit_lvl_set) begin
            nxt_lvl_ff = lvl_ff | wr_bits; // RULE_10
        end
        if (hit_lvl_clr) begin
            nxt_lvl_ff = lvl_ff & ~wr_bits; // RULE_11
        end
    end

    // ownership bit per line, updated on the edge closing the write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            own_ff <= `RST_OWN;
        end else begin
            own_ff <= nxt_own_ff; // RULE_13 RULE_14
        end
    end

    // driver enable bit per line, updated on the edge closing the write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drv_ff <= `RST_DRV;
        end else begin
            drv_ff <= nxt_drv_ff; // RULE_13 RULE_14
        end
    end

    // filter enable bit per line, updated on the edge closing the write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dgl_ff <= `RST_DGL;
        end else begin
            dgl_ff <= nxt_dgl_ff; // RULE_13 RULE_14
        end
    end

    // output level bit per line, updated on the edge closing the write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lvl_ff <= `RST_LVL;
        end else begin
            lvl_ff <= nxt_lvl_ff; // RULE_13 RULE_14
        end
    end

    // ****************************************
    // read data
    // ****************************************

    // status values limited to the lines that exist
    assign own_state = own_ff & `LINE_MASK; // RULE_12
    assign drv_state = drv_ff & `LINE_MASK; // RULE_12
    assign dgl_state = dgl_ff & `LINE_MASK; // RULE_12
    assign lvl_state = lvl_ff & `LINE_MASK; // RULE_12
    assign pin_state = pin_filt & `LINE_MASK; // RULE_12

    // status registers report state; write-only and unmapped read zero
    always @* begin
        case (rd_addr_ff)
            `OFF_OWN_STATE: begin
                nxt_hrdata_ff = own_state; // RULE_03
            end
            `OFF_DRV_STATE: begin
                nxt_hrdata_ff = drv_state; // RULE_06
            end
            `OFF_DGL_STATE: begin
                nxt_hrdata_ff = dgl_state; // RULE_09
            end
            `OFF_LVL_STATE: begin
                nxt_hrdata_ff = lvl_state;
            end
            `OFF_PIN_STATE: begin
                nxt_hrdata_ff = pin_state;
            end
            default: begin
                nxt_hrdata_ff = 32'h00000000; // RULE_13
            end
        endcase
    end

    // read data is loaded in the wait cycle, after any prior write landed
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h00000000;
        end else if (rd_pend_ff) begin
            hrdata_ff <= nxt_hrdata_ff; // RULE_14
        end
    end

    // ****************************************
    // input path
    // ****************************************

    // pad levels come from outside the clock domain
    line_sync u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (pad_in),
        .sync_out (pin_sync)
    );

    // glitch filter steered by the per-line filter state
    deglitch_filter u_filt (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .level_in  (pin_sync),
        .filt_en   (dgl_ff),
        .level_out (pin_filt)
    );

    // peripherals see the filtered pad level
    assign periph_in = pin_filt;

    // ****************************************
    // pad mux
    // ****************************************

    // per line: controller state or peripheral drive, chosen by ownership
    generate
        for (i = 0; i < `LINE_W; i = i + 1) begin : g_pad
            // owned lines drive the stored level and enable
            assign pad_out[i]  = own_ff[i] ? lvl_ff[i] : periph_out[i]; // RULE_01 RULE_02
            assign pad_oe_n[i] = own_ff[i] ? ~drv_ff[i] : ~periph_oe[i]; // RULE_04 RULE_05
        end
    endgenerate

endmodule // io_line_bank

/* tb/io_line_bank_checker.sv */
// assertion checker for the io line control bank
`timescale 1ns/1ns
`include "io_line_defines.vh"

module io_line_bank_checker (
    // clock and reset
    input wire        hclk,
    input wire        hresetn,
    // register bus
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    // pads and peripheral
    input wire [31:0] pad_out,
    input wire [31:0] pad_oe_n,
    input wire [31:0] periph_out,
    input wire [31:0] periph_oe
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire        req = hsel && hready && htrans == `HTRANS_NONSEQ;
    wire [31:0] wd  = hwdata & `LINE_MASK;
    reg         wph_ff;
    reg  [7:0]  wa_ff;
    wire        wdone = wph_ff && hready;
    // remember which write data phase is running
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wph_ff <= 1'b0;
            wa_ff  <= 8'h00;
        end else if (hready) begin
            wph_ff <= req && hwrite;
            wa_ff  <= haddr[7:0];
        end
    end
    a_resp_okay: assert property (hresp == `HRESP_OKAY)
        else $error("response not okay");
    a_read_wait: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (req && hwrite |=> hreadyout [*2])
        else $error("write stalled");
    a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
        else $error("read data moved outside a read");
    a_unimpl_pad: assert property (pad_out[31:30] == periph_out[31:30]
        && pad_oe_n[31:30] == ~periph_oe[31:30]) else $error("absent line not passed through");
    a_own_clear: assert property (wdone && wa_ff == `OFF_OWN_CLR |=>
        (((pad_out ^ periph_out) | (pad_oe_n ^ ~periph_oe)) & $past(wd)) == 32'h0)
        else $error("released line not given to peripheral");
    a_drive_off: assert property (wdone && wa_ff == `OFF_DRV_CLR |=>
        (~pad_oe_n & ~periph_oe & $past(wd)) == 32'h0) else $error("driver still on");
    a_level_high: assert property (wdone && wa_ff == `OFF_LVL_SET |=>
        (~pad_out & periph_out & $past(wd)) == 32'h0) else $error("level not high");
    a_level_low: assert property (wdone && wa_ff == `OFF_LVL_CLR |=>
        (pad_out & ~periph_out & $past(wd)) == 32'h0) else $error("level not low");
endmodule // io_line_bank_checker

bind io_line_bank io_line_bank_checker u_io_line_bank_checker (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pad_out,
    .pad_oe_n, .periph_out, .periph_oe);

/* tb/io_pad_model.sv */
// pad and peripheral model for the io line control bank
`timescale 1ns/1ns

module io_pad_model (
    // clock
    input  wire        hclk,
    // pads
    input  wire [31:0] pad_out,
    input  wire [31:0] pad_oe_n,
    output wire [31:0] pad_in,
    // peripheral drive chosen by the bench
    input  wire [31:0] per_lvl,
    input  wire [31:0] per_en,
    output wire [31:0] periph_out,
    output wire [31:0] periph_oe
);
    reg [31:0] float_ff = 32'h0;
    // a pad without pull and without driver flips every cycle
    always @(posedge hclk) float_ff <= ~float_ff;
    // a driven pad follows its driver
    assign pad_in     = (pad_out & ~pad_oe_n) | (float_ff & pad_oe_n);
    assign periph_out = per_lvl;
    assign periph_oe  = per_en;
endmodule // io_pad_model

/* tb/io_line_bank_tb.sv */
// self-checking testbench for the io line control bank
`timescale 1ns/1ns
`include "io_line_defines.vh"

module io_line_bank_tb;
    reg         hclk = 1'b0;
    reg         hresetn = 1'b0;
    reg         hsel = 1'b0;
    reg  [31:0] haddr = 32'h0;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'b0;
    reg  [31:0] hwdata = 32'h0;
    reg  [31:0] per_lvl = 32'h55555555;
    reg  [31:0] per_en = 32'h0000fff3;
    wire        hreadyout, hresp;
    wire [31:0] hrdata, pad_out, pad_oe_n, pad_in, periph_out, periph_oe, periph_in;
    reg  [31:0] r;
    integer     n_fail = 0;
    integer     cmp_count = 0;
    integer     cyc = 0;

    always #5 hclk = ~hclk;

    io_line_bank u_io_line_bank (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pad_in,
        .pad_out, .pad_oe_n, .periph_out, .periph_oe, .periph_in);
    io_pad_model u_io_pad_model (.hclk, .pad_out, .pad_oe_n, .pad_in, .per_lvl, .per_en,
        .periph_out, .periph_oe);

    // ****
    // bus and compare tasks
    // ****
    task end_sim;
        begin
            $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
            if (n_fail == 0 && cmp_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    // one single transfer: address phase, then data phase
    task xfer(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge hclk);
            hsel <= 1'b1;
            htrans <= `HTRANS_NONSEQ;
            haddr <= {24'h0, a};
            hwrite <= w;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            r = hrdata;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            xfer(1'b0, a, 32'h0);
            chk(r, e);
        end
    endtask
    // reset values of the ownership, driver and filter state registers and pad enables
    task t_reset_vals;
        begin
            rd(`OFF_OWN_STATE, `RST_OWN);
            rd(`OFF_DRV_STATE, `RST_DRV);
            rd(`OFF_DGL_STATE, `RST_DGL);
            chk(pad_oe_n & `LINE_MASK, `LINE_MASK);
        end
    endtask
    // every set/clear pair, zero writes, absent lines, write-only reads
    task t_pairs;
        integer i;
        reg [7:0] b;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                b = {i[3:0], 4'h0};
                wr(b + 8'h04, 32'hffffffff);
                rd(b + 8'h08, 32'h0);
                wr(b, 32'hffffffff);
                rd(b + 8'h08, `LINE_MASK);
                wr(b + 8'h04, 32'h00ff00ff);
                wr(b, 32'h0);
                wr(b + 8'h04, 32'h0);
                rd(b + 8'h08, 32'h3f00ff00);
                rd(b, 32'h0);
                rd(b + 8'h04, 32'h0);
            end
        end
    endtask
    // pad drive, loop back and hand-over to the peripheral
    task t_pads;
        begin
            wr(`OFF_OWN_SET, 32'hffffffff);
            wr(`OFF_DRV_CLR, 32'hffffffff);
            wr(`OFF_DRV_SET, 32'h000000ff);
            wr(`OFF_LVL_CLR, 32'hffffffff);
            wr(`OFF_LVL_SET, 32'h0000000f);
            #1;
            chk(pad_oe_n & `LINE_MASK, 32'h3fffff00);
            chk(pad_out & 32'hff, 32'h0f);
            repeat (4) @(posedge hclk);
            chk(periph_in & 32'hff, 32'h0f);
            xfer(1'b0, `OFF_PIN_STATE, 32'h0);
            chk(r & 32'hff, 32'h0f);
            // floating lines flip each cycle: filtered ones freeze, others follow
            @(posedge hclk);
            #1;
            r = periph_in;
            @(posedge hclk);
            #1;
            chk((r ^ periph_in) & 32'h00ffff00, 32'h00ff0000);
            wr(`OFF_OWN_CLR, 32'h0000000c);
            #1;
            chk(pad_out & 32'hc, 32'h4);
            chk(pad_oe_n & 32'hc, 32'hc);
            rd(`OFF_OWN_STATE, 32'h3ffffff3);
            per_lvl <= ~per_lvl;
            @(posedge hclk);
            #1;
            chk(pad_out & 32'hc, ~32'h55555555 & 32'hc);
        end
    endtask
    // unmapped and read-only places, then a second reset
    task t_misc;
        begin
            rd(8'h0c, 32'h0);
            rd(8'hfc, 32'h0);
            wr(`OFF_OWN_STATE, 32'h0);
            rd(`OFF_OWN_STATE, 32'h3ffffff3);
            @(posedge hclk);
            hresetn <= 1'b0;
            repeat (2) @(posedge hclk);
            hresetn <= 1'b1;
            rd(`OFF_OWN_STATE, `RST_OWN);
        end
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_vals;
        t_pairs;
        t_pads;
        t_misc;
        end_sim;
    end
    // hang guard
    always @(posedge hclk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            n_fail = n_fail + 1;
            end_sim;
        end
    end
endmodule // io_line_bank_tb
